// ==== hdl/ckgc_defines.svh ====
`ifndef CKGC_DEFINES_SVH
`define CKGC_DEFINES_SVH

// Register byte addresses on the Avalon-MM slave port.
`define CKGC_ADDR_SLOW_CFG 32'hFFFFFD50
`define CKGC_ADDR_MAIN_OSC 32'hFFFFFC20
`define CKGC_ADDR_PLL_CFG 32'hFFFFFC28
`define CKGC_ADDR_USB_PLL 32'hFFFFFC1C
`define CKGC_ADDR_STATUS 32'hFFFFFC68
`define CKGC_ADDR_IRQ_MASK 32'hFFFFFC6C

// Slow clock configuration fields.
`define CKGC_SLOW_RC_EN_BIT 0
`define CKGC_SLOW_XEN_BIT 1
`define CKGC_SLOW_BYP_BIT 2
`define CKGC_SLOW_SEL_BIT 3
`define CKGC_SLOW_CFG_RESET 4'h1

// Main oscillator register fields.
`define CKGC_MOR_EN_BIT 0
`define CKGC_MOR_BYP_BIT 1
`define CKGC_MOR_CNT_LSB 8
`define CKGC_MOR_CNT_MSB 15

// PLL configuration register fields.
`define CKGC_PLL_DIV_LSB 0
`define CKGC_PLL_DIV_MSB 7
`define CKGC_PLL_CNT_LSB 8
`define CKGC_PLL_CNT_MSB 13
`define CKGC_PLL_GAIN_LSB 16
`define CKGC_PLL_GAIN_MSB 26

// USB PLL register fields.
`define CKGC_USB_EN_BIT 16
`define CKGC_USB_CNT_LSB 20
`define CKGC_USB_CNT_MSB 23
`define CKGC_USB_BIAS_BIT 24
`define CKGC_USB_MULT 6'h28

// Status and mask bit positions.
`define CKGC_ST_MAIN_BIT 0
`define CKGC_ST_LOCK_BIT 1
`define CKGC_ST_USB_BIT 6
`define CKGC_ST_READY_BIT 8

// Timing: core clock, nominal slow clock, and derived divider counts.
`define CKGC_CORE_CLK_HZ 40000000
`define CKGC_SLOW_CLK_HZ 32768
`define CKGC_SLOW_DIV (`CKGC_CORE_CLK_HZ / `CKGC_SLOW_CLK_HZ)
`define CKGC_SLOW_PRESCALE 8
`define CKGC_STARTUP_SLOW_PERIODS 4

`endif

// ==== hdl/ckgc_pkg.sv ====
`default_nettype none
package ckgc_pkg;

  // Slow clock configuration held in the backup domain.
  typedef struct packed {
    logic slow_source_select;
    logic slow_crystal_bypass;
    logic slow_crystal_enable;
    logic rc_osc_enable;
  } ckgc_slow_cfg_t;

  // Enables and selects driven to the analog oscillator and PLL cells.
  typedef struct packed {
    logic rc_osc_enable;
    logic slow_crystal_enable;
    logic slow_crystal_bypass;
    logic slow_source_select;
    logic main_osc_enable;
    logic main_osc_bypass;
    logic pll_power;
    logic pll_in_enable;
    logic pll_out_enable;
    logic usb_pll_enable;
    logic usb_bias_enable;
  } ckgc_osc_ctrl_t;

  typedef enum logic {
    CKGC_BUS_IDLE,
    CKGC_BUS_ACK
  } ckgc_bus_state_t;

endpackage : ckgc_pkg
`default_nettype wire

// ==== hdl/ckgc_countdown.sv ====
`timescale 1ns/1ps
`default_nettype none
module ckgc_countdown #(
  parameter int W = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic tick_i,
  input wire logic run_i,
  output logic done_o
);
  logic [W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // A load always wins, so a restart in mid-count reloads and drops the flag.
  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (load_i) begin
      cnt_d = value_i;
      done_d = 1'b0;
    end else if (!run_i) begin
      done_d = 1'b0;
    end else if (tick_i && !done_q) begin
      if (cnt_q == '0) begin
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Registers only.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q && run_i;
endmodule : ckgc_countdown
`default_nettype wire

// ==== hdl/ckgc_slow_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ckgc_defines.svh"
module ckgc_slow_tick (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic ext_mode_i,
  input wire logic ext_pin_i,
  output logic slow_tick_o,
  output logic slow8_tick_o
);
  logic [10:0] div_q, div_d;
  logic [2:0] pre_q, pre_d;
  logic pin_q, pin_d;
  logic tick;

  // In bypass the external pin's rising edge is the slow clock; otherwise the
  // oscillator is modelled by dividing the core clock.
  always_comb begin
    div_d = div_q;
    pin_d = ext_pin_i;
    tick = 1'b0;
    if (!run_i) begin
      div_d = '0;
    end else if (ext_mode_i) begin
      tick = ext_pin_i && !pin_q;
    end else if (div_q == 11'(`CKGC_SLOW_DIV - 1)) begin
      div_d = '0;
      tick = 1'b1;
    end else begin
      div_d = div_q + 11'h001;
    end
    pre_d = tick ? pre_q + 3'h1 : pre_q;
  end

  // Registers only.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      div_q <= '0;
      pre_q <= '0;
      pin_q <= 1'b0;
    end else begin
      div_q <= div_d;
      pre_q <= pre_d;
      pin_q <= pin_d;
    end
  end

  assign slow_tick_o = tick;
  assign slow8_tick_o = tick && (pre_q == 3'(`CKGC_SLOW_PRESCALE - 1));
endmodule : ckgc_slow_tick
`default_nettype wire

// ==== hdl/ckgc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ckgc_defines.svh"
// Overview of operation
// - Slow source selector 0 picks the RC oscillator, 1 picks the crystal.
// - RC enable and crystal enable bits switch their oscillators on or off.
// - Crystal bypass takes the external slow clock from the slow crystal pin.
// - Backup power-on sets RC on, crystal off, selector zero.
// - Slow configuration survives system reset while backup supply stays.
// - System startup completes within four slow clock periods.
// - After reset the main oscillator is off and slow clock runs.
// - Clearing main oscillator enable immediately clears the stable flag.
// - Enable with count clears stable, counts down on slow clock by eight.
// - Count zero sets stable flag; unmasked it raises the interrupt.
// - Divider takes 1 to 255; zero forces divider and PLL outputs low.
// - Reset sets the divider ratio to zero.
// - Output is source times gain plus one over divider; gain zero powers down.
// - Re-enable or change clears lock, reloads settle count on slow clock.
// - USB PLL multiplies the main oscillator by fixed forty.
// - USB enable clears its lock, enables bias, counts on slow by eight.
module ckgc_top (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic backup_por_i,
  input wire logic slow_crystal_in_pin_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output ckgc_pkg::ckgc_osc_ctrl_t osc_ctrl_o,
  output logic [7:0] pll_div_o,
  output logic [10:0] pll_gain_field_o,
  output logic [5:0] usb_pll_mult_o,
  output logic slow_tick_o,
  output logic system_ready_o,
  output logic irq_o
);
  ckgc_pkg::ckgc_bus_state_t bus_q, bus_d;
  ckgc_pkg::ckgc_slow_cfg_t slow_cfg_q, slow_cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] mor_q, mor_d, pll_q, pll_d, usb_q, usb_d, mask_q, mask_d;
  logic [2:0] boot_q, boot_d;
  logic [31:0] status, wdata;
  logic wr_ack, wr_slow, wr_mor, wr_pll, wr_usb, wr_mask;
  logic slow_run, slow8_tick, main_stable, pll_lock, usb_lock;
  logic main_en, usb_en, gain_nz, div_nz;

  // Merges the enabled byte lanes of a write into the old register value.
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_be

  // Bus handshake: every request waits exactly one cycle, then is answered.
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      ckgc_pkg::CKGC_BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          bus_d = ckgc_pkg::CKGC_BUS_ACK;
        end
      end
      ckgc_pkg::CKGC_BUS_ACK: bus_d = ckgc_pkg::CKGC_BUS_IDLE;
      default: bus_d = ckgc_pkg::CKGC_BUS_IDLE;
    endcase
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_q == ckgc_pkg::CKGC_BUS_IDLE);
  assign wr_ack = avs_write_i && (bus_q == ckgc_pkg::CKGC_BUS_ACK);
  assign wr_slow = wr_ack && (avs_address_i == `CKGC_ADDR_SLOW_CFG);
  assign wr_mor = wr_ack && (avs_address_i == `CKGC_ADDR_MAIN_OSC);
  assign wr_pll = wr_ack && (avs_address_i == `CKGC_ADDR_PLL_CFG);
  assign wr_usb = wr_ack && (avs_address_i == `CKGC_ADDR_USB_PLL);
  assign wr_mask = wr_ack && (avs_address_i == `CKGC_ADDR_IRQ_MASK);

  // Status word: flags from the counters plus the startup indication.
  always_comb begin
    status = '0;
    status[`CKGC_ST_MAIN_BIT] = main_stable;
    status[`CKGC_ST_LOCK_BIT] = pll_lock;
    status[`CKGC_ST_USB_BIT] = usb_lock;
    status[`CKGC_ST_READY_BIT] = system_ready_o;
  end

  // Read data is captured in the waiting cycle; unmapped addresses read zero.
  always_comb begin
    rdata_d = rdata_q;
    if (avs_read_i && bus_q == ckgc_pkg::CKGC_BUS_IDLE) begin
      case (avs_address_i)
        `CKGC_ADDR_SLOW_CFG: rdata_d = {28'h0000000, slow_cfg_q};
        `CKGC_ADDR_MAIN_OSC: rdata_d = mor_q;
        `CKGC_ADDR_PLL_CFG: rdata_d = pll_q;
        `CKGC_ADDR_USB_PLL: rdata_d = usb_q;
        `CKGC_ADDR_STATUS: rdata_d = status;
        `CKGC_ADDR_IRQ_MASK: rdata_d = mask_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Next values of the system-domain control registers; unused bits stay zero.
  always_comb begin
    mor_d = mor_q;
    pll_d = pll_q;
    usb_d = usb_q;
    mask_d = mask_q;
    wdata = 32'h00000000;
    if (wr_mor) begin
      mor_d = merge_be(mor_q, avs_writedata_i, avs_byteenable_i) & 32'h0000FF03;
    end
    if (wr_pll) begin
      pll_d = merge_be(pll_q, avs_writedata_i, avs_byteenable_i) & 32'h07FF3FFF;
    end
    if (wr_usb) begin
      wdata = merge_be(usb_q, avs_writedata_i, avs_byteenable_i);
      usb_d = wdata & 32'h00F10000;
      usb_d[`CKGC_USB_BIAS_BIT] = wdata[`CKGC_USB_EN_BIT];
    end
    if (wr_mask) begin
      mask_d = merge_be(mask_q, avs_writedata_i, avs_byteenable_i) & 32'h00000043;
    end
  end

  // System reset clears main oscillator, divider and gain, keeping the
  // slow clock as the running clock.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bus_q <= ckgc_pkg::CKGC_BUS_IDLE;
      rdata_q <= '0;
      mor_q <= '0;
      pll_q <= '0;
      usb_q <= '0;
      mask_q <= '0;
    end else begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      mor_q <= mor_d;
      pll_q <= pll_d;
      usb_q <= usb_d;
      mask_q <= mask_d;
    end
  end

  // Backup-domain configuration: only the backup power-on reset touches it,
  // so a system reset leaves the slow clock source alone.
  always_comb begin
    slow_cfg_d = slow_cfg_q;
    if (wr_slow && avs_byteenable_i[0]) begin
      slow_cfg_d = ckgc_pkg::ckgc_slow_cfg_t'(avs_writedata_i[3:0]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (backup_por_i) begin
      slow_cfg_q <= ckgc_pkg::ckgc_slow_cfg_t'(`CKGC_SLOW_CFG_RESET);
    end else begin
      slow_cfg_q <= slow_cfg_d;
    end
  end

  // The selected source must be on for the slow clock to tick; the software
  // switching sequence keeps the old source alive across the change.
  assign slow_run = slow_cfg_q.slow_source_select
                  ? (slow_cfg_q.slow_crystal_enable || slow_cfg_q.slow_crystal_bypass)
                  : slow_cfg_q.rc_osc_enable;

  ckgc_slow_tick u_tick (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .run_i(slow_run),
    .ext_mode_i(slow_cfg_q.slow_source_select && slow_cfg_q.slow_crystal_bypass),
    .ext_pin_i(slow_crystal_in_pin_i),
    .slow_tick_o(slow_tick_o),
    .slow8_tick_o(slow8_tick)
  );

  // Startup counter saturates once the fixed number of slow periods has passed.
  always_comb begin
    boot_d = boot_q;
    if (slow_tick_o && boot_q != 3'(`CKGC_STARTUP_SLOW_PERIODS)) begin
      boot_d = boot_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      boot_q <= '0;
    end else begin
      boot_q <= boot_d;
    end
  end

  assign system_ready_o = (boot_q == 3'(`CKGC_STARTUP_SLOW_PERIODS));

  assign main_en = mor_q[`CKGC_MOR_EN_BIT];
  assign usb_en = usb_q[`CKGC_USB_EN_BIT];
  assign gain_nz = (pll_q[`CKGC_PLL_GAIN_MSB:`CKGC_PLL_GAIN_LSB] != 11'h000);
  assign div_nz = (pll_q[`CKGC_PLL_DIV_MSB:`CKGC_PLL_DIV_LSB] != 8'h00);

  // Main oscillator start-up: a write with enable set reloads; clearing enable
  // drops the flag at once.
  ckgc_countdown #(.W(8)) u_main_cnt (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .load_i(wr_mor && mor_d[`CKGC_MOR_EN_BIT]),
    .value_i(mor_d[`CKGC_MOR_CNT_MSB:`CKGC_MOR_CNT_LSB]),
    .tick_i(slow8_tick),
    .run_i(main_en),
    .done_o(main_stable)
  );

  // PLL settle: any write reloads on the full slow clock rate.
  ckgc_countdown #(.W(6)) u_pll_cnt (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .load_i(wr_pll),
    .value_i(pll_d[`CKGC_PLL_CNT_MSB:`CKGC_PLL_CNT_LSB]),
    .tick_i(slow_tick_o),
    .run_i(gain_nz && div_nz),
    .done_o(pll_lock)
  );

  // USB PLL settle on the slow clock divided by eight.
  ckgc_countdown #(.W(4)) u_usb_cnt (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .load_i(wr_usb && usb_d[`CKGC_USB_EN_BIT]),
    .value_i(usb_d[`CKGC_USB_CNT_MSB:`CKGC_USB_CNT_LSB]),
    .tick_i(slow8_tick),
    .run_i(usb_en),
    .done_o(usb_lock)
  );

  // Analog control outputs straight from registers.
  always_comb begin
    osc_ctrl_o.rc_osc_enable = slow_cfg_q.rc_osc_enable;
    osc_ctrl_o.slow_crystal_enable = slow_cfg_q.slow_crystal_enable;
    osc_ctrl_o.slow_crystal_bypass = slow_cfg_q.slow_crystal_bypass;
    osc_ctrl_o.slow_source_select = slow_cfg_q.slow_source_select;
    osc_ctrl_o.main_osc_enable = main_en;
    osc_ctrl_o.main_osc_bypass = mor_q[`CKGC_MOR_BYP_BIT];
    osc_ctrl_o.pll_power = gain_nz;
    osc_ctrl_o.pll_in_enable = div_nz;
    osc_ctrl_o.pll_out_enable = div_nz && gain_nz;
    osc_ctrl_o.usb_pll_enable = usb_en;
    osc_ctrl_o.usb_bias_enable = usb_q[`CKGC_USB_BIAS_BIT];
  end

  assign pll_div_o = pll_q[`CKGC_PLL_DIV_MSB:`CKGC_PLL_DIV_LSB];
  assign pll_gain_field_o = pll_q[`CKGC_PLL_GAIN_MSB:`CKGC_PLL_GAIN_LSB];
  assign usb_pll_mult_o = `CKGC_USB_MULT;
  assign avs_readdata_o = rdata_q;
  // Level interrupt while any unmasked flag is set.
  assign irq_o = |(status & mask_q);

  // Helper for the startup check: counts slow ticks since reset.
  logic [2:0] seen_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      seen_q <= '0;
    end else if (slow_tick_o && seen_q != 3'h7) begin
      seen_q <= seen_q + 3'h1;
    end
  end

  sequence s_mor_enable_write;
    wr_mor && mor_d[`CKGC_MOR_EN_BIT];
  endsequence

  sequence s_flag_low;
    !main_stable;
  endsequence

  a_stable_on_disable: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(main_en) |-> !main_stable) else $error("stable flag kept after disable");
  a_main_reload: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_mor_enable_write |=> s_flag_low) else $error("stable flag not cleared on enable");
  a_main_irq: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(main_stable) && mask_q[`CKGC_ST_MAIN_BIT] |-> irq_o) else $error("irq missing");
  a_pll_zero_div: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !div_nz |-> !osc_ctrl_o.pll_out_enable && !pll_lock) else $error("pll out with div zero");
  a_div_reset: assert property (@(posedge core_clk_i)
    reset_i |=> pll_div_o == 8'h00) else $error("divider not zero after reset");
  a_backup_default: assert property (@(posedge core_clk_i)
    backup_por_i |=> slow_cfg_q == ckgc_pkg::ckgc_slow_cfg_t'(`CKGC_SLOW_CFG_RESET))
    else $error("backup defaults wrong");
  a_backup_kept: assert property (@(posedge core_clk_i)
    reset_i && !backup_por_i |=> $stable(slow_cfg_q)) else $error("slow config lost on reset");
  a_pll_relock: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_pll |=> !pll_lock [*2]) else $error("lock not cleared on pll write");
  a_usb_bias: assert property (@(posedge core_clk_i) disable iff (reset_i)
    usb_en |-> osc_ctrl_o.usb_bias_enable) else $error("bias off with usb pll on");
  a_ready_time: assert property (@(posedge core_clk_i) disable iff (reset_i)
    system_ready_o |-> seen_q >= 3'(`CKGC_STARTUP_SLOW_PERIODS)) else $error("ready too early");
  // The other bound: once enough slow periods have passed, ready must stand.
  a_ready_bound: assert property (@(posedge core_clk_i) disable iff (reset_i)
    seen_q >= 3'(`CKGC_STARTUP_SLOW_PERIODS) |-> system_ready_o) else $error("ready too late");
endmodule : ckgc_top
`default_nettype wire

// ==== dv/ckgc_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ckgc_osc_model #(
  parameter int HALF = 610
) (
  input wire logic core_clk_i,
  input wire logic ext_on_i,
  output logic pin_o
);
  int cnt = 0;
  logic lvl = 1'b0;
  logic flt = 1'b0;

  // A free external source of about one slow period; the half period may be stretched for slow runs.
  always @(posedge core_clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    flt <= ~flt;
    if (cnt == HALF - 1) begin
      lvl <= ~lvl;
    end
  end

  // An unconnected pin shows a level that changes every cycle, never a clean last value.
  assign pin_o = ext_on_i ? lvl : flt;
endmodule : ckgc_osc_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ckgc_defines.svh"
module testbench;
  localparam logic [31:0] A_SLOW = `CKGC_ADDR_SLOW_CFG;
  localparam logic [31:0] A_MAIN = `CKGC_ADDR_MAIN_OSC;
  localparam logic [31:0] A_PLL = `CKGC_ADDR_PLL_CFG;
  localparam logic [31:0] A_USB = `CKGC_ADDR_USB_PLL;
  localparam logic [31:0] A_ST = `CKGC_ADDR_STATUS;
  localparam logic [31:0] A_MASK = `CKGC_ADDR_IRQ_MASK;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic backup_por_i = 1'b1;
  logic ext_on = 1'b0;
  logic pin;
  logic [31:0] avs_address_i = 32'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  ckgc_pkg::ckgc_osc_ctrl_t osc_ctrl_o;
  logic [7:0] pll_div_o;
  logic [10:0] pll_gain_field_o;
  logic [5:0] usb_pll_mult_o;
  logic slow_tick_o;
  logic system_ready_o;
  logic irq_o;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int tk;
  logic [31:0] seed = 32'h44E3;
  logic [31:0] d;
  logic [31:0] q;
  logic [31:0] mdl [logic [31:0]];

  // Free-running core clock at 40 MHz.
  always #12.5 core_clk_i = ~core_clk_i;

  ckgc_top ckgc_top_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .backup_por_i(backup_por_i),
    .slow_crystal_in_pin_i(pin), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .osc_ctrl_o(osc_ctrl_o), .pll_div_o(pll_div_o),
    .pll_gain_field_o(pll_gain_field_o), .usb_pll_mult_o(usb_pll_mult_o),
    .slow_tick_o(slow_tick_o), .system_ready_o(system_ready_o), .irq_o(irq_o)
  );

  ckgc_osc_model ckgc_osc_model_inst (.core_clk_i(core_clk_i), .ext_on_i(ext_on), .pin_o(pin));

  // The whole sequence needs roughly 45000 cycles; the ceiling leaves more than twice that.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 120000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] wmask(input logic [31:0] a);
    case (a)
      A_SLOW: return 32'h0000000F;
      A_MAIN: return 32'h0000FF03;
      A_PLL: return 32'h07FF3FFF;
      A_USB: return 32'h00F10000;
      A_MASK: return 32'h00000043;
      default: return 32'h0;
    endcase
  endfunction : wmask

  // One Avalon transfer; the request is held until waitrequest is seen low at an edge.
  // Only the bench's cycle ceiling ends a wait that never gets an answer.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  // Writes update the reference copy only in the lanes and fields that the register owns.
  task automatic wr(input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be = 4'hF);
    logic [31:0] m;
    m = wmask(a) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1'b1, a, wd, be);
    if (mdl.exists(a)) mdl[a] = (mdl[a] & ~m) | (wd & m);
    if (a == A_USB) mdl[a][24] = mdl[a][16];
    @(negedge core_clk_i);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
    check(q, mdl.exists(a) ? mdl[a] : 32'h0);
  endtask : rd_chk

  // Polls status until the flag takes the wanted level or the read budget runs out.
  task automatic st_wait(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      bus(1'b0, A_ST, 32'h0, 4'hF);
      n++;
    end while (q[b] !== v && n < lim);
  endtask : st_wait

  task automatic wait_ticks(input int n);
    int c;
    c = 0;
    tk = 0;
    while (tk < n && c < n * 1300 + 200) begin
      @(posedge core_clk_i);
      c++;
      if (slow_tick_o === 1'b1) tk++;
    end
  endtask : wait_ticks

  task automatic chk_slow();
    check({28'h0, osc_ctrl_o.slow_source_select, osc_ctrl_o.slow_crystal_bypass,
           osc_ctrl_o.slow_crystal_enable, osc_ctrl_o.rc_osc_enable}, mdl[A_SLOW]);
  endtask : chk_slow

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    backup_por_i <= 1'b0;
    mdl[A_SLOW] = 32'h1;
    mdl[A_MAIN] = 32'h0;
    mdl[A_PLL] = 32'h0;
    mdl[A_USB] = 32'h0;
    mdl[A_MASK] = 32'h0;
    foreach (mdl[a]) rd_chk(a);
    seed = lfsr(seed);
    wr(A_ST + 32'h8, seed);
    rd_chk(A_ST + 32'h8);
    check(osc_ctrl_o.main_osc_enable, 1'b0);
    check(osc_ctrl_o.pll_in_enable, 1'b0);
    check(system_ready_o, 1'b0);
    wait_ticks(4);
    repeat (4) @(posedge core_clk_i);
    check(system_ready_o, 1'b1);
    $display("test reset done");
    // Crystal brought up, selected, then the RC dropped, in the documented order.
    wr(A_SLOW, 32'h3);
    chk_slow();
    wait_ticks(2);
    wr(A_SLOW, 32'hB);
    chk_slow();
    wait_ticks(5);
    wr(A_SLOW, 32'hA);
    chk_slow();
    wr(A_SLOW, 32'h5, 4'hE);
    rd_chk(A_SLOW);
    ext_on <= 1'b1;
    wr(A_SLOW, 32'hE);
    wr(A_SLOW, 32'hC);
    chk_slow();
    wait_ticks(2);
    check(tk, 2);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd_chk(A_SLOW);
    check(system_ready_o, 1'b0);
    wr(A_SLOW, 32'hD);
    wait_ticks(1);
    wr(A_SLOW, 32'h5);
    wait_ticks(5);
    wr(A_SLOW, 32'h1);
    chk_slow();
    ext_on <= 1'b0;
    $display("test slow clock done");
    wr(A_MAIN, 32'h1);
    st_wait(0, 1'b0, 1);
    check(q[0], 1'b0);
    st_wait(0, 1'b1, 3500);
    check(q[0], 1'b1);
    wr(A_MASK, 32'h1);
    check(irq_o, 1'b1);
    wr(A_MAIN, 32'h101);
    repeat (3000) @(posedge core_clk_i);
    wr(A_MAIN, 32'h1);
    st_wait(0, 1'b0, 1);
    check(q[0], 1'b0);
    st_wait(0, 1'b1, 3500);
    check(q[0], 1'b1);
    wr(A_MAIN, 32'h0);
    st_wait(0, 1'b0, 1);
    check(q[0], 1'b0);
    check(irq_o, 1'b0);
    wr(A_MAIN, 32'h2);
    check({osc_ctrl_o.main_osc_bypass, osc_ctrl_o.main_osc_enable}, 2'h2);
    rd_chk(A_MAIN);
    $display("test main oscillator done");
    wr(A_PLL, 32'h00050000);
    check({osc_ctrl_o.pll_power, osc_ctrl_o.pll_out_enable}, 2'h2);
    seed = lfsr(seed);
    d = (seed & 32'h07FF00FF) | 32'h00010201;
    wr(A_PLL, d);
    st_wait(1, 1'b0, 1);
    check(q[1], 1'b0);
    check({pll_gain_field_o, pll_div_o}, {d[26:16], d[7:0]});
    st_wait(1, 1'b1, 1400);
    check(q[1], 1'b1);
    wr(A_PLL, d & 32'h0000FFFF);
    check(osc_ctrl_o.pll_power, 1'b0);
    rd_chk(A_PLL);
    $display("test pll done");
    check(usb_pll_mult_o, 6'h28);
    wr(A_USB, 32'h00010000);
    st_wait(6, 1'b0, 1);
    check(q[6], 1'b0);
    check({osc_ctrl_o.usb_pll_enable, osc_ctrl_o.usb_bias_enable}, 2'h3);
    rd_chk(A_USB);
    st_wait(6, 1'b1, 3500);
    check(q[6], 1'b1);
    $display("test usb pll done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
